// file: verilog/cmsl_defines.svh
// Constants of the chip mode, security and low-power block
`ifndef CMSL_DEFINES_SVH
`define CMSL_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CMSL_REG_MODE    8'h00
`define CMSL_REG_MISC    8'h04
`define CMSL_REG_SECSTAT 8'h08
`define CMSL_REG_LPCTL   8'h0C
`define CMSL_REG_LPSTAT  8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMSL_MISC_FLASH_VIS   0
`define CMSL_MISC_OSC_SEL     1
`define CMSL_SEC_SECURED      0
`define CMSL_SEC_DEBUG_BLOCK  1
`define CMSL_SEC_MEM_DISABLE  2
`define CMSL_SEC_CHECK_DONE   3
`define CMSL_SEC_CHECK_PASS   4
`define CMSL_SEC_DEBUG_ACTIVE 5
`define CMSL_LPCTL_PSEUDO     0
`define CMSL_LPCTL_GATE_LSB   8
// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define CMSL_MODE_SPECIAL_SINGLE 3'h0
`define CMSL_MODE_NORMAL_SINGLE  3'h4
`define CMSL_MODE_SPECIAL_PERIPH 3'h6
`define CMSL_MODE_RESET          3'h0
`define CMSL_HTRANS_NONSEQ       2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define CMSL_CLK_PERIOD_NS  50
`define CMSL_BLANK_CHECK_NS 10000
`define CMSL_BLANK_CHECK_CYC \
    ((`CMSL_BLANK_CHECK_NS + `CMSL_CLK_PERIOD_NS - 1) / `CMSL_CLK_PERIOD_NS)
`endif

// file: verilog/cmsl_pkg.sv
// Types of the chip mode, security and low-power block
package cmsl_pkg;
    // ----------------------------------------
    // Strap pins sampled at reset release
    // ----------------------------------------
    typedef struct packed {
        logic mode_strap_high;
        logic mode_strap_mid;
        logic mode_strap_low;
        logic flash_visible_strap;
        logic oscillator_select_strap;
    } cmsl_strap_type;
    // ----------------------------------------
    // Low-power and blank-check states
    // ----------------------------------------
    typedef enum logic [1:0] {
        CMSL_LP_RUN,
        CMSL_LP_STOP_FULL,
        CMSL_LP_STOP_PSEUDO,
        CMSL_LP_WAIT
    } cmsl_lp_type;
    typedef enum logic [1:0] {
        CMSL_BC_IDLE,
        CMSL_BC_CHECK,
        CMSL_BC_DONE
    } cmsl_bc_type;
endpackage

// file: verilog/cmsl_rst_sync.sv
// Reset release synchroniser
`timescale 1ns/1ns
`default_nettype none
module cmsl_rst_sync (
    // Clock and raw reset
    input  wire logic clk,
    input  wire logic reset_n_raw,
    // Synchronised reset
    output logic      reset_n_sync
);
    logic meta_q;
    logic hold_q;

    // Assert at once, release two edges later
    always_ff @(posedge clk or negedge reset_n_raw) begin
        if (!reset_n_raw) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            meta_q <= 1'b1;
            hold_q <= meta_q;
        end
    end
    assign reset_n_sync = hold_q;
endmodule
`default_nettype wire

// file: verilog/cmsl_blank_check.sv
// Blank-check routine run before security may be lifted
`timescale 1ns/1ns
`default_nettype none
`include "cmsl_defines.svh"
module cmsl_blank_check #(
    parameter int CHECK_CYC = `CMSL_BLANK_CHECK_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    input  wire logic flash_blank,
    input  wire logic eeprom_blank,
    // Result
    output logic      done,
    output logic      pass
);
    import cmsl_pkg::*;
    cmsl_bc_type state_q;
    logic [15:0] cnt_q;
    logic        pass_q;
    wire         cnt_end = (cnt_q == 16'(CHECK_CYC - 1));
    wire         blank   = flash_blank & eeprom_blank;

    // Both arrays must read blank over the whole check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CMSL_BC_IDLE;
            cnt_q   <= 16'h0000;
            pass_q  <= 1'b0;
        end else begin
            unique case (state_q)
                CMSL_BC_IDLE: begin
                    if (start) begin
                        state_q <= CMSL_BC_CHECK;
                        pass_q  <= 1'b1;
                    end
                end
                CMSL_BC_CHECK: begin
                    cnt_q  <= cnt_q + 16'h0001;
                    pass_q <= pass_q & blank;
                    if (cnt_end) begin
                        state_q <= CMSL_BC_DONE;
                    end
                end
                CMSL_BC_DONE: begin
                end
                default: state_q <= CMSL_BC_IDLE;
            endcase
        end
    end
    assign done = (state_q == CMSL_BC_DONE);
    assign pass = done & pass_q;
endmodule
`default_nettype wire

// file: verilog/cmsl_top.sv
// Chip mode, security and low-power configuration block
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cmsl_defines.svh"
module cmsl_top #(
    parameter int NPERIPH   = 8,
    parameter int CHECK_CYC = `CMSL_BLANK_CHECK_CYC
) (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    // Straps and nonvolatile state
    input  wire cmsl_pkg::cmsl_strap_type STRAPS,
    input  wire logic                   NV_SECURED,
    input  wire logic                   FLASH_BLANK,
    input  wire logic                   EEPROM_BLANK,
    input  wire logic                   BACKDOOR_KEY_OK,
    input  wire logic                   DEBUG_ACTIVATE,
    // Low-power events
    input  wire logic                   STOP_INSTRUCTION,
    input  wire logic                   WAIT_INSTRUCTION,
    input  wire logic                   EXT_IRQ,
    input  wire logic                   TICK_WAKE,
    input  wire logic                   PERIPH_IRQ,
    // AHB-Lite slave
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic      [31:0]            HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    // Configuration outputs
    output logic      [2:0]             MODE_BITS,
    output logic                        FLASH_MAPPED,
    output logic                        EEPROM_MAPPED,
    output logic                        OSC_COLPITTS,
    output logic                        DEBUG_ACTIVE,
    output logic                        DEBUG_BLOCKED,
    output logic                        SEC_PROGRAM_EN,
    // Clock enables
    output logic                        OSC_EN,
    output logic                        CPU_CLK_EN,
    output logic                        CPU_BUS_HOLD,
    output logic                        TICK_WDOG_CLK_EN,
    output logic      [NPERIPH-1:0]     PERIPH_CLK_EN
);
    import cmsl_pkg::*;

    // ----------------------------------------
    // Reset and strap load
    // ----------------------------------------
    logic rst_n;
    logic loaded_q;
    cmsl_rst_sync u_rst (
        .clk          (CLK),
        .reset_n_raw  (RESET_N),
        .reset_n_sync (rst_n)
    );
    wire load_now = ~loaded_q;

    function automatic logic is_expanded(input logic [2:0] m);
        return (m != `CMSL_MODE_SPECIAL_SINGLE) && (m != `CMSL_MODE_NORMAL_SINGLE);
    endfunction

    // Limited switching: special modes other than peripheral move freely, normal single chip may
    // only widen to a normal expanded mode; peripheral mode is never taken
    function automatic logic mode_write_ok(input logic [2:0] cur,
                                           input logic [2:0] nxt);
        return (nxt != `CMSL_MODE_SPECIAL_PERIPH) &&
               (~cur[2] || (cur == `CMSL_MODE_NORMAL_SINGLE && nxt[2] && nxt[0]));
    endfunction

    wire [2:0] strap_mode = {STRAPS.mode_strap_high, STRAPS.mode_strap_mid,
                             STRAPS.mode_strap_low};

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic [7:0]  addr_q;
    logic        wr_q;
    logic        rd_q;
    logic        hready_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdata;
    wire  accept   = HSEL & HREADY & (HTRANS == `CMSL_HTRANS_NONSEQ);
    wire  wr_mode  = wr_q & (addr_q == `CMSL_REG_MODE);
    wire  wr_misc  = wr_q & (addr_q == `CMSL_REG_MISC);
    wire  wr_lpctl = wr_q & (addr_q == `CMSL_REG_LPCTL);

    // Reads take one wait state so they always see the latest write
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            addr_q   <= 8'h00;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            hready_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_q <= accept & HWRITE;
            rd_q <= accept & ~HWRITE;
            if (accept) begin
                addr_q <= HADDR[7:0];
            end
            if (accept & ~HWRITE) begin
                hready_q <= 1'b0;
            end else if (rd_q) begin
                hready_q <= 1'b1;
                hrdata_q <= rdata;
            end
        end
    end
    assign HREADYOUT = hready_q;
    assign HRDATA    = hrdata_q;
    assign HRESP     = 1'b0;

    // ----------------------------------------
    // Mode, map and oscillator
    // ----------------------------------------
    logic [2:0] mode_q;
    logic       flash_vis_q;
    logic       osc_q;
    wire        mode_wr_ok = wr_mode & mode_write_ok(mode_q, HWDATA[2:0]);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            loaded_q    <= 1'b0;
            mode_q      <= `CMSL_MODE_RESET;
            flash_vis_q <= 1'b0;
            osc_q       <= 1'b0;
        end else if (load_now) begin
            loaded_q    <= 1'b1;
            mode_q      <= strap_mode;
            flash_vis_q <= STRAPS.flash_visible_strap;
            osc_q       <= STRAPS.oscillator_select_strap;
        end else begin
            if (mode_wr_ok) begin
                mode_q <= HWDATA[2:0];
            end
            if (wr_misc && !mode_q[2]) begin
                flash_vis_q <= HWDATA[`CMSL_MISC_FLASH_VIS];
            end
        end
    end

    // ----------------------------------------
    // Security
    // ----------------------------------------
    logic secured_q;
    logic mem_dis_q;
    logic dbg_act_q;
    logic bc_start_q;
    logic bc_done;
    logic bc_pass;

    cmsl_blank_check #(
        .CHECK_CYC (CHECK_CYC)
    ) u_bc (
        .clk          (CLK),
        .rst_n        (rst_n),
        .start        (bc_start_q),
        .flash_blank  (FLASH_BLANK),
        .eeprom_blank (EEPROM_BLANK),
        .done         (bc_done),
        .pass         (bc_pass)
    );

    // Secured out of every reset; nonvolatile bits decide after release
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            secured_q  <= 1'b1;
            mem_dis_q  <= 1'b0;
            dbg_act_q  <= 1'b0;
            bc_start_q <= 1'b0;
        end else if (load_now) begin
            secured_q  <= NV_SECURED;
            mem_dis_q  <= NV_SECURED & is_expanded(strap_mode);
            dbg_act_q  <= (strap_mode == `CMSL_MODE_SPECIAL_SINGLE);
            bc_start_q <= NV_SECURED &
                          (strap_mode == `CMSL_MODE_SPECIAL_SINGLE);
        end else begin
            bc_start_q <= 1'b0;
            if (BACKDOOR_KEY_OK || bc_pass) begin
                secured_q <= 1'b0;
                mem_dis_q <= 1'b0;
            end
            if (DEBUG_ACTIVATE) begin
                dbg_act_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    logic [2:0] mode_out_q;
    logic       flash_map_q;
    logic       ee_map_q;
    logic       osc_out_q;
    logic       dbg_out_q;
    logic       dbg_blk_q;
    logic       sec_prog_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode_out_q  <= `CMSL_MODE_RESET;
            flash_map_q <= 1'b0;
            ee_map_q    <= 1'b0;
            osc_out_q   <= 1'b0;
            dbg_out_q   <= 1'b0;
            dbg_blk_q   <= 1'b1;
            sec_prog_q  <= 1'b0;
        end else begin
            mode_out_q  <= mode_q;
            flash_map_q <= flash_vis_q & ~mem_dis_q;
            ee_map_q    <= loaded_q & ~mem_dis_q;
            osc_out_q   <= osc_q;
            dbg_blk_q   <= secured_q;
            dbg_out_q   <= dbg_act_q & ~secured_q;
            sec_prog_q  <= loaded_q & ~secured_q;
        end
    end
    assign MODE_BITS      = mode_out_q;
    assign FLASH_MAPPED   = flash_map_q;
    assign EEPROM_MAPPED  = ee_map_q;
    assign OSC_COLPITTS   = osc_out_q;
    assign DEBUG_ACTIVE   = dbg_out_q;
    assign DEBUG_BLOCKED  = dbg_blk_q;
    assign SEC_PROGRAM_EN = sec_prog_q;

    // ----------------------------------------
    // Low-power control
    // ----------------------------------------
    cmsl_lp_type        lp_q;
    cmsl_lp_type        lp_d;
    logic               pseudo_sel_q;
    logic [NPERIPH-1:0] gate_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pseudo_sel_q <= 1'b0;
            gate_q       <= '0;
        end else if (wr_lpctl) begin
            pseudo_sel_q <= HWDATA[`CMSL_LPCTL_PSEUDO];
            gate_q       <= HWDATA[`CMSL_LPCTL_GATE_LSB +: NPERIPH];
        end
    end

    always_comb begin
        lp_d = lp_q;
        unique case (lp_q)
            CMSL_LP_RUN: begin
                if (STOP_INSTRUCTION) begin
                    lp_d = pseudo_sel_q ? CMSL_LP_STOP_PSEUDO
                                        : CMSL_LP_STOP_FULL;
                end else if (WAIT_INSTRUCTION) begin
                    lp_d = CMSL_LP_WAIT;
                end
            end
            CMSL_LP_STOP_FULL: begin
                if (EXT_IRQ) begin
                    lp_d = CMSL_LP_RUN;
                end
            end
            CMSL_LP_STOP_PSEUDO: begin
                if (EXT_IRQ || TICK_WAKE) begin
                    lp_d = CMSL_LP_RUN;
                end
            end
            CMSL_LP_WAIT: begin
                if (EXT_IRQ || TICK_WAKE || PERIPH_IRQ) begin
                    lp_d = CMSL_LP_RUN;
                end
            end
        endcase
    end

    wire in_run  = (lp_d == CMSL_LP_RUN);
    wire in_wait = (lp_d == CMSL_LP_WAIT);
    wire in_full = (lp_d == CMSL_LP_STOP_FULL);

    logic               osc_en_q;
    logic               cpu_en_q;
    logic               hold_q;
    logic               tick_en_q;
    logic [NPERIPH-1:0] per_en_q;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lp_q      <= CMSL_LP_RUN;
            osc_en_q  <= 1'b1;
            cpu_en_q  <= 1'b1;
            hold_q    <= 1'b0;
            tick_en_q <= 1'b1;
        end else begin
            lp_q      <= lp_d;
            osc_en_q  <= ~in_full;
            cpu_en_q  <= in_run;
            hold_q    <= in_wait;
            tick_en_q <= ~in_full;
        end
    end

    // Peripherals run in run and wait; each may gate itself in wait
    genvar gi;
    generate
        for (gi = 0; gi < NPERIPH; gi++) begin : g_per
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    per_en_q[gi] <= 1'b1;
                end else begin
                    per_en_q[gi] <= in_run | (in_wait & ~gate_q[gi]);
                end
            end
        end
    endgenerate

    assign OSC_EN           = osc_en_q;
    assign CPU_CLK_EN       = cpu_en_q;
    assign CPU_BUS_HOLD     = hold_q;
    assign TICK_WDOG_CLK_EN = tick_en_q;
    assign PERIPH_CLK_EN    = per_en_q;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire  [31:0] rd_mode  = {29'h0, mode_q};
    wire  [31:0] rd_misc  = {30'h0, osc_q, flash_vis_q};
    wire  [31:0] rd_sec   = {26'h0, dbg_act_q & ~secured_q, bc_pass, bc_done,
                             mem_dis_q, secured_q, secured_q};
    wire  [31:0] rd_lpctl = 32'({gate_q, 7'h00, pseudo_sel_q});
    wire  [31:0] rd_lpst  = {30'h0, lp_q};

    always_comb begin
        unique case (addr_q)
            `CMSL_REG_MODE:    rdata = rd_mode;
            `CMSL_REG_MISC:    rdata = rd_misc;
            `CMSL_REG_SECSTAT: rdata = rd_sec;
            `CMSL_REG_LPCTL:   rdata = rd_lpctl;
            `CMSL_REG_LPSTAT:  rdata = rd_lpst;
            default:           rdata = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

// file: verif/cmsl_checker_assertions.sv
// Port-level assertions of the chip mode, security and low-power block
`timescale 1ns/1ns
`default_nettype none
module cmsl_checker
    import cmsl_pkg::*;
#(
    parameter int NPERIPH = 8
) (
    // Clock, reset and straps
    input wire logic           CLK, RESET_N, NV_SECURED,
    input wire cmsl_strap_type STRAPS,
    // Low-power events
    input wire logic           STOP_INSTRUCTION, WAIT_INSTRUCTION,
    input wire logic           EXT_IRQ, TICK_WAKE, PERIPH_IRQ,
    // Bus
    input wire logic           HSEL, HWRITE, HREADY, HREADYOUT,
    input wire logic [1:0]     HTRANS,
    // Configuration and clock enables
    input wire logic [2:0]     MODE_BITS,
    input wire logic           FLASH_MAPPED, EEPROM_MAPPED, OSC_COLPITTS,
    input wire logic           DEBUG_ACTIVE, DEBUG_BLOCKED,
    input wire logic           OSC_EN, CPU_CLK_EN, CPU_BUS_HOLD, TICK_WDOG_CLK_EN,
    input wire logic [NPERIPH-1:0] PERIPH_CLK_EN
);
    // ----------------------------------------
    // Edges since release; straps settle by 6
    // ----------------------------------------
    logic [2:0] up_q;
    wire  [2:0] sm = {STRAPS.mode_strap_high, STRAPS.mode_strap_mid, STRAPS.mode_strap_low};
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_run; up_q == 3'h7 && CPU_CLK_EN && OSC_EN && !CPU_BUS_HOLD; endsequence
    sequence s_wait; CPU_BUS_HOLD; endsequence
    sequence s_pstop; OSC_EN && !CPU_CLK_EN && !CPU_BUS_HOLD; endsequence
    sequence s_fstop; !OSC_EN; endsequence
    sequence s_read; HSEL && HREADY && HTRANS == 2'h2 && !HWRITE; endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_MODE_LOAD: assert property (up_q == 3'h6 |-> MODE_BITS == sm)
        else $error("mode bits differ from straps");
    AST_FLASH_VIS: assert property (up_q == 3'h6 && !NV_SECURED |->
        FLASH_MAPPED == STRAPS.flash_visible_strap) else $error("flash map differs from strap");
    AST_OSC_SEL: assert property (up_q == 3'h7 |->
        OSC_COLPITTS == STRAPS.oscillator_select_strap) else $error("oscillator select wrong");
    AST_DBG_BOOT: assert property (up_q == 3'h6 && !NV_SECURED |->
        DEBUG_ACTIVE == (sm == 3'h0)) else $error("debug state at boot wrong");
    AST_DBG_BLOCK: assert property (DEBUG_BLOCKED |-> !DEBUG_ACTIVE)
        else $error("debug active while blocked");
    AST_SEC_EXP: assert property (up_q == 3'h6 && NV_SECURED && sm != 3'h0 && sm != 3'h4 |->
        !FLASH_MAPPED && !EEPROM_MAPPED && DEBUG_BLOCKED) else $error("secured expanded leak");
    AST_STOP_ENTRY: assert property (s_run ##0 STOP_INSTRUCTION |=>
        !CPU_CLK_EN && !CPU_BUS_HOLD && PERIPH_CLK_EN == '0) else $error("stop entry wrong");
    AST_WAIT_ENTRY: assert property (s_run ##0 (WAIT_INSTRUCTION && !STOP_INSTRUCTION) |=>
        s_wait ##0 (!CPU_CLK_EN && OSC_EN && TICK_WDOG_CLK_EN)) else $error("wait entry wrong");
    AST_FULL_STOP: assert property (s_fstop |->
        !CPU_CLK_EN && !TICK_WDOG_CLK_EN && PERIPH_CLK_EN == '0) else $error("clock runs in stop");
    AST_FULL_WAKE: assert property (s_fstop ##0 EXT_IRQ |=> OSC_EN && CPU_CLK_EN)
        else $error("no wake from stop");
    AST_FULL_HOLD: assert property (s_fstop ##0 (TICK_WAKE && !EXT_IRQ) |=> !OSC_EN)
        else $error("tick woke full stop");
    AST_PSEUDO: assert property (s_pstop |-> TICK_WDOG_CLK_EN && PERIPH_CLK_EN == '0)
        else $error("pseudo stop enables wrong");
    AST_PSEUDO_WAKE: assert property (s_pstop ##0 TICK_WAKE |=> CPU_CLK_EN)
        else $error("no tick wake from pseudo stop");
    AST_WAIT_WAKE: assert property (s_wait ##0 PERIPH_IRQ |=> !CPU_BUS_HOLD && CPU_CLK_EN)
        else $error("no wake from wait");
    AST_READ: assert property (s_read |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
endmodule
`default_nettype wire

// file: verif/cmsl_partner.sv
// Board straps and debug host beside the block
`timescale 1ns/1ns
`default_nettype none
module cmsl_partner (
    // Clock and board settings
    input  wire logic               clk,
    input  wire logic [2:0]         mode,
    input  wire logic               fv, osc, sec, erased,
    // Host requests
    input  wire logic               dbg_req, key_req,
    // Pins toward the block
    output cmsl_pkg::cmsl_strap_type straps,
    output logic                    nv_secured, flash_blank, eeprom_blank,
    output logic                    debug_activate, backdoor_key_ok
);
    import cmsl_pkg::*;
    // Peripheral mode fights the bus: never strapped
    assign straps = {(mode == 3'h6) ? 3'h4 : mode, fv, osc};
    assign nv_secured = sec;
    assign flash_blank = erased;
    assign eeprom_blank = erased;
    always_ff @(posedge clk) begin
        debug_activate <= dbg_req;
        backdoor_key_ok <= key_req;
    end
endmodule
`default_nettype wire

// file: verif/chip_mode_security_lowpower_tb.sv
// Self-checking bench of the chip mode, security and low-power block
`timescale 1ns/1ns
`default_nettype none
`include "cmsl_defines.svh"
module chip_mode_security_lowpower_tb;
    import cmsl_pkg::*;
    localparam int NP = 8;
    logic CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, NV_SECURED, FLASH_BLANK;
    logic EEPROM_BLANK, BACKDOOR_KEY_OK, DEBUG_ACTIVATE, FLASH_MAPPED, EEPROM_MAPPED;
    logic OSC_COLPITTS, DEBUG_ACTIVE, DEBUG_BLOCKED, SEC_PROGRAM_EN, OSC_EN, CPU_CLK_EN;
    logic CPU_BUS_HOLD, TICK_WDOG_CLK_EN, fv, osc, sec, er;
    logic [31:0] HADDR, HWDATA, HRDATA, r, seed;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE, MODE_BITS, cm, em, st, w;
    logic [NP-1:0] PERIPH_CLK_EN, gate;
    logic [6:0] ev;
    cmsl_strap_type STRAPS;
    int num_errors = 0;
    int n_tests = 0;
    wire HREADY = HREADYOUT;
    cmsl_partner BRD (.clk(CLK), .mode(cm), .fv, .osc, .sec, .erased(er), .dbg_req(ev[5]),
        .key_req(ev[6]), .straps(STRAPS), .nv_secured(NV_SECURED), .flash_blank(FLASH_BLANK),
        .eeprom_blank(EEPROM_BLANK), .debug_activate(DEBUG_ACTIVATE),
        .backdoor_key_ok(BACKDOOR_KEY_OK));
    cmsl_top #(.NPERIPH(NP), .CHECK_CYC(4)) DUT (.CLK, .RESET_N, .STRAPS, .NV_SECURED,
        .FLASH_BLANK, .EEPROM_BLANK, .BACKDOOR_KEY_OK, .DEBUG_ACTIVATE,
        .STOP_INSTRUCTION(ev[0]), .WAIT_INSTRUCTION(ev[1]), .EXT_IRQ(ev[2]),
        .TICK_WAKE(ev[3]), .PERIPH_IRQ(ev[4]), .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
        .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MODE_BITS, .FLASH_MAPPED,
        .EEPROM_MAPPED, .OSC_COLPITTS, .DEBUG_ACTIVE, .DEBUG_BLOCKED, .SEC_PROGRAM_EN,
        .OSC_EN, .CPU_CLK_EN, .CPU_BUS_HOLD, .TICK_WDOG_CLK_EN, .PERIPH_CLK_EN);
    // ----------------------------------------
    // Expectation helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [2:0] next_mode(input logic [2:0] c, input logic [2:0] v);
        if (v == 3'h6 || (c[2] && !(c == 3'h4 && v[2] && v[0]))) return c;
        return v;
    endfunction
    // Blank check unsecures only in mode 000
    function automatic logic [2:0] sec_stat(input logic [2:0] m, input logic s, input logic e);
        logic q;
        q = s && !(m == 3'h0 && e);
        return {q && m != 3'h0 && m != 3'h4, q, q};
    endfunction
    // ----------------------------------------
    // Drivers and comparison
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        {HSEL, HTRANS, HWRITE, HADDR, HSIZE} <= {1'b1, 2'h2, wr, 24'h0, a, 3'h2};
        do @(posedge CLK); while (HREADY !== 1'b1);
        {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, d};
        do @(posedge CLK); while (HREADY !== 1'b1);
        r = HRDATA;
    endtask
    task automatic pulse(input int b);
        @(posedge CLK) ev[b] <= 1'b1;
        @(posedge CLK) ev <= 7'h00;
        repeat (3) @(posedge CLK);
        #1;
    endtask
    // Straps move only in reset
    task automatic rst(input logic [2:0] m, input logic s, input logic [31:0] x);
        @(posedge CLK) {RESET_N, cm, sec, fv, osc, er} <= {1'b0, m, s, x[0], x[1], x[2]};
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (14) @(posedge CLK);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and scenarios
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        print_verdict();
    end
    initial begin
        {RESET_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA, HSIZE, ev} = '0;
        {cm, fv, osc, sec, er} = '0;
        seed = 32'h4dca;
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            em = (i[2:0] == 3'h6) ? 3'h4 : i[2:0];
            rst(i[2:0], i[3], seed);
            st = sec_stat(em, i[3], seed[2]);
            bus(1'b0, `CMSL_REG_MODE, 32'h0);
            chk({HRESP, r[2:0]}, em);
            bus(1'b0, `CMSL_REG_MISC, 32'h0);
            chk(r[1:0], seed[1:0]);
            chk({OSC_COLPITTS, FLASH_MAPPED, EEPROM_MAPPED}, {seed[1], seed[0] & !st[2], !st[2]});
            bus(1'b0, `CMSL_REG_SECSTAT, 32'h0);
            chk(r[2:0], st);
            if (i[3] && em == 3'h0) chk({r[4:3], SEC_PROGRAM_EN}, {seed[2], 1'b1, seed[2]});
            pulse(5);
            chk(DEBUG_ACTIVE, !st[0]);
            if (st[0]) begin
                pulse(6);
                bus(1'b0, `CMSL_REG_SECSTAT, 32'h0);
                chk(r[1:0], 2'h0);
            end else for (int j = 0; j < 3; j++) begin
                w = (j == 0) ? 3'h6 : (j == 1) ? 3'h5 : seed[5:3];
                em = next_mode(em, w);
                bus(1'b1, `CMSL_REG_MODE, {29'h0, w});
                bus(1'b0, `CMSL_REG_MODE, 32'h0);
                chk(r[2:0], em);
            end
        end
        bus(1'b1, 8'h20, seed);
        bus(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0);
        rst(3'h4, 1'b0, seed);
        gate = seed[15:8];
        bus(1'b1, `CMSL_REG_LPCTL, {16'h0, gate, 8'h00});
        pulse(1);
        chk({CPU_CLK_EN, CPU_BUS_HOLD, OSC_EN, PERIPH_CLK_EN}, {3'b011, ~gate});
        pulse(4);
        chk(CPU_CLK_EN, 1'b1);
        pulse(0);
        chk({OSC_EN, TICK_WDOG_CLK_EN, CPU_CLK_EN, PERIPH_CLK_EN}, 32'h0);
        pulse(3);
        chk(OSC_EN, 1'b0);
        pulse(2);
        chk({OSC_EN, CPU_CLK_EN}, 2'h3);
        bus(1'b1, `CMSL_REG_LPCTL, 32'h1);
        pulse(0);
        chk({OSC_EN, TICK_WDOG_CLK_EN, CPU_CLK_EN, PERIPH_CLK_EN}, {3'b110, 8'h00});
        pulse(3);
        chk(CPU_CLK_EN, 1'b1);
        print_verdict();
    end
endmodule
bind cmsl_top cmsl_checker #(.NPERIPH(NPERIPH)) CHK (.CLK, .RESET_N, .NV_SECURED, .STRAPS,
    .STOP_INSTRUCTION, .WAIT_INSTRUCTION, .EXT_IRQ, .TICK_WAKE, .PERIPH_IRQ, .HSEL, .HWRITE,
    .HREADY, .HREADYOUT, .HTRANS, .MODE_BITS, .FLASH_MAPPED, .EEPROM_MAPPED, .OSC_COLPITTS,
    .DEBUG_ACTIVE, .DEBUG_BLOCKED, .OSC_EN, .CPU_CLK_EN, .CPU_BUS_HOLD, .TICK_WDOG_CLK_EN,
    .PERIPH_CLK_EN);
`default_nettype wire
